// ===== logic/viq_pkg.sv
// shared constants for the vectored interrupt command and status registers
package viq_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int          NUM_SOURCES      = 32;
    localparam int          ID_WIDTH         = 5;
    localparam int          ADDR_WIDTH       = 12;
    localparam int          DATA_WIDTH       = 32;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] NORMAL_VECTOR_READ_OFS      = 12'h100;
    localparam logic [11:0] FAST_VECTOR_READ_OFS        = 12'h104;
    localparam logic [11:0] CURRENT_ID_OFS              = 12'h108;
    localparam logic [11:0] PENDING_STATUS_OFS          = 12'h10c;
    localparam logic [11:0] MASK_STATUS_OFS             = 12'h110;
    localparam logic [11:0] CORE_LINE_STATUS_OFS        = 12'h114;
    localparam logic [11:0] SOURCE_ENABLE_COMMAND_OFS   = 12'h120;
    localparam logic [11:0] SOURCE_DISABLE_COMMAND_OFS  = 12'h124;
    localparam logic [11:0] PENDING_CLEAR_COMMAND_OFS   = 12'h128;
    localparam logic [11:0] PENDING_SET_COMMAND_OFS     = 12'h12c;
    localparam logic [11:0] END_OF_SERVICE_COMMAND_OFS  = 12'h130;
    localparam logic [11:0] SPURIOUS_HANDLER_VECTOR_OFS = 12'h134;
    localparam logic [11:0] DEBUG_CONTROL_OFS           = 12'h138;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int          FAST_SOURCE_BIT    = 0;
    localparam int          SYSTEM_SOURCE_BIT  = 1;
    localparam int          FAST_LINE_STATE    = 0;
    localparam int          NORMAL_LINE_STATE  = 1;
    localparam int          PROTECTION_ENABLE  = 0;
    localparam int          GLOBAL_LINE_MASK   = 1;
    localparam int          VECTOR_STEP_SHIFT  = 2;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] SPURIOUS_VECTOR_RESET = 32'h0000_0000;
    localparam logic [1:0]  DEBUG_CONTROL_RESET   = 2'h0;
    localparam logic [31:0] ENABLE_RESET          = 32'h0000_0000;
    localparam logic [31:0] PENDING_RESET         = 32'h0000_0000;
    localparam logic [31:0] VECTOR_BASE_DEFAULT   = 32'h0000_1000;

    // ------------------------------------------------------------------
    // bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;

endpackage : viq_pkg

// ===== logic/viq_arbiter.sv
// picks the lowest-numbered enabled pending normal source
`timescale 1ns/1ps
module viq_arbiter #(
    parameter int N  = 32,
    parameter int IW = 5
) (
    input  wire logic [N-1:0]  req,
    output logic               valid,
    output logic [IW-1:0]      id
);

    // ------------------------------------------------------------------
    // fixed priority scan, bit 0 is the fast source and never competes
    // ------------------------------------------------------------------
    always_comb begin
        valid = 1'b0;
        id    = '0;
        for (int i = N - 1; i >= 1; i--) begin
            if (req[i]) begin
                valid = 1'b1;
                id    = IW'(i);
            end
        end
    end

endmodule // viq_arbiter

// ===== logic/viq_regs.sv
// command, status and debug registers of the vectored interrupt unit
//
// Function
// - mask status bit reads source enabled
// - line status bit0 shows fast line active
// - line status bit1 shows normal line active
// - enable command ones enable sources
// - disable command ones disable sources
// - clear command ones clear pending
// - set command ones force pending
// - any end-of-service write signals completion
// - spurious vector returned when nothing current
// - debug bit0 turns protection mode on
// - debug bit1 zero drives lines normally
// - debug bit1 one holds lines inactive
// - pending status bit reads source pending
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module viq_regs #(
    parameter int          NSRC        = viq_pkg::NUM_SOURCES,
    parameter logic [31:0] VECTOR_BASE = viq_pkg::VECTOR_BASE_DEFAULT
) (
    input  wire logic                  SYS_CLK,
    input  wire logic                  RESET_N,
    input  wire logic [NSRC-1:0]       SOURCE_IN,
    output logic                       FAST_REQUEST_LINE_N,
    output logic                       NORMAL_REQUEST_LINE_N,
    input  wire logic [11:0]           S_AXI_AWADDR,
    input  wire logic                  S_AXI_AWVALID,
    output logic                       S_AXI_AWREADY,
    input  wire logic [31:0]           S_AXI_WDATA,
    input  wire logic [3:0]            S_AXI_WSTRB,
    input  wire logic                  S_AXI_WVALID,
    output logic                       S_AXI_WREADY,
    output logic [1:0]                 S_AXI_BRESP,
    output logic                       S_AXI_BVALID,
    input  wire logic                  S_AXI_BREADY,
    input  wire logic [11:0]           S_AXI_ARADDR,
    input  wire logic                  S_AXI_ARVALID,
    output logic                       S_AXI_ARREADY,
    output logic [31:0]                S_AXI_RDATA,
    output logic [1:0]                 S_AXI_RRESP,
    output logic                       S_AXI_RVALID,
    input  wire logic                  S_AXI_RREADY
);

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lane_mask(input logic [3:0] strb);
        return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    endfunction

    function automatic logic is_mapped(input logic [11:0] a);
        logic hit;
        hit = 1'b0;
        if (a == viq_pkg::NORMAL_VECTOR_READ_OFS) begin
            hit = 1'b1;
        end else if (a >= viq_pkg::FAST_VECTOR_READ_OFS
                     && a <= viq_pkg::CORE_LINE_STATUS_OFS && a[1:0] == 2'h0) begin
            hit = 1'b1;
        end else if (a >= viq_pkg::SOURCE_ENABLE_COMMAND_OFS
                     && a <= viq_pkg::DEBUG_CONTROL_OFS && a[1:0] == 2'h0) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [NSRC-1:0]                   enable;
    logic [NSRC-1:0]                   pending;
    logic [31:0]                       spurious_vector_value;
    logic                              protection_enable;
    logic                              global_line_mask;
    logic                              in_service;
    logic [viq_pkg::ID_WIDTH-1:0]      current_id;
    logic [11:0]                       aw_addr;
    logic [31:0]                       w_data;
    logic [3:0]                        w_strb;

    logic                              arb_valid;
    logic [viq_pkg::ID_WIDTH-1:0]      arb_id;
    logic                              aw_fire;
    logic                              w_fire;
    logic                              ar_fire;
    logic                              wr_do;
    logic [31:0]                       wr_bits;
    logic                              ack;
    logic                              eos;
    logic                              fast_active;
    logic [NSRC-1:0]                   cmd_enable;
    logic [NSRC-1:0]                   cmd_disable;
    logic [NSRC-1:0]                   cmd_clear;
    logic [NSRC-1:0]                   cmd_set;
    logic [NSRC-1:0]                   ack_clear;
    logic [NSRC-1:0]                   next_pending;
    logic [NSRC-1:0]                   next_enable;
    logic [31:0]                       next_rdata;

    assign aw_fire = S_AXI_AWVALID && S_AXI_AWREADY;
    assign w_fire  = S_AXI_WVALID && S_AXI_WREADY;
    assign ar_fire = S_AXI_ARVALID && S_AXI_ARREADY;
    // both halves held and no response outstanding
    assign wr_do   = !S_AXI_AWREADY && !S_AXI_WREADY && !S_AXI_BVALID;
    assign wr_bits = w_data & lane_mask(w_strb);

    viq_arbiter #(
        .N  (NSRC),
        .IW (viq_pkg::ID_WIDTH)
    ) u_arbiter (
        .req   (pending & enable),
        .valid (arb_valid),
        .id    (arb_id)
    );

    // ------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------
    always_comb begin
        cmd_enable  = '0;
        cmd_disable = '0;
        cmd_clear   = '0;
        cmd_set     = '0;
        eos         = 1'b0;
        if (wr_do) begin
            if (aw_addr == viq_pkg::SOURCE_ENABLE_COMMAND_OFS) begin
                cmd_enable = wr_bits[NSRC-1:0];
            end else if (aw_addr == viq_pkg::SOURCE_DISABLE_COMMAND_OFS) begin
                cmd_disable = wr_bits[NSRC-1:0];
            end else if (aw_addr == viq_pkg::PENDING_CLEAR_COMMAND_OFS) begin
                cmd_clear = wr_bits[NSRC-1:0];
            end else if (aw_addr == viq_pkg::PENDING_SET_COMMAND_OFS) begin
                cmd_set = wr_bits[NSRC-1:0];
            end else if (aw_addr == viq_pkg::END_OF_SERVICE_COMMAND_OFS) begin
                eos = 1'b1;
            end
        end
    end

    // protected mode moves the acknowledge from the vector read to a write,
    // so a debugger peeking at the vector does not disturb the sequence
    assign ack = arb_valid && !in_service
                 && ((ar_fire && !protection_enable
                      && S_AXI_ARADDR == viq_pkg::NORMAL_VECTOR_READ_OFS)
                     || (wr_do && protection_enable
                         && aw_addr == viq_pkg::NORMAL_VECTOR_READ_OFS));

    always_comb begin
        ack_clear = '0;
        if (ack) begin
            ack_clear[arb_id] = 1'b1;
        end
    end

    // set and live source win over a clear in the same cycle
    assign next_pending = (pending & ~cmd_clear & ~ack_clear)
                          | SOURCE_IN | cmd_set;
    assign next_enable  = (enable | cmd_enable) & ~cmd_disable;

    // ------------------------------------------------------------------
    // source state
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            pending <= viq_pkg::PENDING_RESET;
            enable  <= viq_pkg::ENABLE_RESET;
        end else begin
            pending <= next_pending;
            enable  <= next_enable;
        end
    end

    // ------------------------------------------------------------------
    // service level
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            in_service <= 1'b0;
            current_id <= '0;
        end else if (ack) begin
            in_service <= 1'b1;
            current_id <= arb_id;
        end else if (eos) begin
            in_service <= 1'b0;
            current_id <= '0;
        end
    end

    // ------------------------------------------------------------------
    // software written configuration
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            spurious_vector_value <= viq_pkg::SPURIOUS_VECTOR_RESET;
            protection_enable     <= viq_pkg::DEBUG_CONTROL_RESET[viq_pkg::PROTECTION_ENABLE];
            global_line_mask      <= viq_pkg::DEBUG_CONTROL_RESET[viq_pkg::GLOBAL_LINE_MASK];
        end else if (wr_do) begin
            if (aw_addr == viq_pkg::SPURIOUS_HANDLER_VECTOR_OFS) begin
                spurious_vector_value <= (spurious_vector_value & ~lane_mask(w_strb))
                                         | wr_bits;
            end else if (aw_addr == viq_pkg::DEBUG_CONTROL_OFS && w_strb[0]) begin
                protection_enable <= w_data[viq_pkg::PROTECTION_ENABLE];
                global_line_mask  <= w_data[viq_pkg::GLOBAL_LINE_MASK];
            end
        end
    end

    // ------------------------------------------------------------------
    // request lines toward the core, active low
    // ------------------------------------------------------------------
    assign fast_active = pending[viq_pkg::FAST_SOURCE_BIT] && enable[viq_pkg::FAST_SOURCE_BIT];

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            FAST_REQUEST_LINE_N   <= 1'b1;
            NORMAL_REQUEST_LINE_N <= 1'b1;
        end else if (global_line_mask) begin
            FAST_REQUEST_LINE_N   <= 1'b1;
            NORMAL_REQUEST_LINE_N <= 1'b1;
        end else begin
            FAST_REQUEST_LINE_N   <= !fast_active;
            NORMAL_REQUEST_LINE_N <= !(arb_valid && !in_service && !ack);
        end
    end

    // ------------------------------------------------------------------
    // read data
    // ------------------------------------------------------------------
    always_comb begin
        next_rdata = 32'h0000_0000;
        if (S_AXI_ARADDR == viq_pkg::NORMAL_VECTOR_READ_OFS) begin
            if (in_service) begin
                next_rdata = VECTOR_BASE
                             + (32'(current_id) << viq_pkg::VECTOR_STEP_SHIFT);
            end else if (arb_valid) begin
                next_rdata = VECTOR_BASE + (32'(arb_id) << viq_pkg::VECTOR_STEP_SHIFT);
            end else begin
                next_rdata = spurious_vector_value;
            end
        end else if (S_AXI_ARADDR == viq_pkg::FAST_VECTOR_READ_OFS) begin
            next_rdata = fast_active ? VECTOR_BASE : spurious_vector_value;
        end else if (S_AXI_ARADDR == viq_pkg::CURRENT_ID_OFS) begin
            next_rdata = 32'(current_id);
        end else if (S_AXI_ARADDR == viq_pkg::PENDING_STATUS_OFS) begin
            next_rdata = 32'(pending);
        end else if (S_AXI_ARADDR == viq_pkg::MASK_STATUS_OFS) begin
            next_rdata = 32'(enable);
        end else if (S_AXI_ARADDR == viq_pkg::CORE_LINE_STATUS_OFS) begin
            next_rdata[viq_pkg::FAST_LINE_STATE]   = !FAST_REQUEST_LINE_N;
            next_rdata[viq_pkg::NORMAL_LINE_STATE] = !NORMAL_REQUEST_LINE_N;
        end else if (S_AXI_ARADDR == viq_pkg::SPURIOUS_HANDLER_VECTOR_OFS) begin
            next_rdata = spurious_vector_value;
        end else if (S_AXI_ARADDR == viq_pkg::DEBUG_CONTROL_OFS) begin
            next_rdata[viq_pkg::PROTECTION_ENABLE] = protection_enable;
            next_rdata[viq_pkg::GLOBAL_LINE_MASK]  = global_line_mask;
        end
    end

    // ------------------------------------------------------------------
    // write channels: address and data taken in either order
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_AWREADY <= 1'b1;
            aw_addr       <= '0;
        end else if (aw_fire) begin
            S_AXI_AWREADY <= 1'b0;
            aw_addr       <= S_AXI_AWADDR;
        end else if (wr_do) begin
            S_AXI_AWREADY <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_WREADY <= 1'b1;
            w_data       <= '0;
            w_strb       <= '0;
        end else if (w_fire) begin
            S_AXI_WREADY <= 1'b0;
            w_data       <= S_AXI_WDATA;
            w_strb       <= S_AXI_WSTRB;
        end else if (wr_do) begin
            S_AXI_WREADY <= 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP  <= viq_pkg::RESP_OKAY;
        end else if (wr_do) begin
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= is_mapped(aw_addr) ? viq_pkg::RESP_OKAY : viq_pkg::RESP_SLVERR;
        end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // read channel: one read at a time, data one edge after the address
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
            S_AXI_RDATA   <= 32'h0000_0000;
            S_AXI_RRESP   <= viq_pkg::RESP_OKAY;
        end else if (ar_fire) begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID  <= 1'b1;
            S_AXI_RDATA   <= next_rdata;
            S_AXI_RRESP   <= is_mapped(S_AXI_ARADDR) ? viq_pkg::RESP_OKAY
                                                     : viq_pkg::RESP_SLVERR;
        end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_ARREADY <= 1'b1;
            S_AXI_RVALID  <= 1'b0;
        end
    end

endmodule // viq_regs

// ===== sim/viq_regs_assertions.sv
// port-level checks for the vectored interrupt register block
`timescale 1ns/1ps
module viq_regs_assertions #(
    parameter logic [31:0] VECTOR_BASE = viq_pkg::VECTOR_BASE_DEFAULT
) (
    input wire logic        SYS_CLK,
    input wire logic        RESET_N,
    input wire logic        FAST_REQUEST_LINE_N,
    input wire logic        NORMAL_REQUEST_LINE_N,
    input wire logic [11:0] S_AXI_AWADDR,
    input wire logic        S_AXI_AWVALID,
    input wire logic        S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0]  S_AXI_WSTRB,
    input wire logic        S_AXI_WVALID,
    input wire logic        S_AXI_WREADY,
    input wire logic [1:0]  S_AXI_BRESP,
    input wire logic        S_AXI_BVALID,
    input wire logic        S_AXI_BREADY,
    input wire logic [11:0] S_AXI_ARADDR,
    input wire logic        S_AXI_ARVALID,
    input wire logic        S_AXI_ARREADY,
    input wire logic [31:0] S_AXI_RDATA,
    input wire logic [1:0]  S_AXI_RRESP,
    input wire logic        S_AXI_RVALID
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESET_N);
    wire logic wr_take = S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY;
    // shadow of debug word; leads the debug register by one edge and the request lines by two, hence the two-edge margin below
    logic [1:0] dbg;
    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N)
            dbg <= 2'h0;
        else if (wr_take && S_AXI_AWADDR == viq_pkg::DEBUG_CONTROL_OFS && S_AXI_WSTRB[0])
            dbg <= S_AXI_WDATA[1:0];
    end
    sequence s_wr_take;
        wr_take;
    endsequence
    sequence s_rd_take;
        S_AXI_ARVALID && S_AXI_ARREADY;
    endsequence
    // the design raises the response one edge after it has both halves, so two edges after a
    // joint take; an older response still waiting would delay it
    a_write_answer: assert property (s_wr_take ##0 !S_AXI_BVALID |-> ##2 S_AXI_BVALID)
        else $error("write response late");
    a_bresp_stands: assert property (S_AXI_BVALID && !S_AXI_BREADY |=>
        S_AXI_BVALID && $stable(S_AXI_BRESP)) else $error("write response dropped");
    a_read_answer: assert property (s_rd_take |=> S_AXI_RVALID)
        else $error("read data late");
    a_unmapped_read: assert property (s_rd_take ##0 S_AXI_ARADDR == 12'h118 |=>
        S_AXI_RRESP == viq_pkg::RESP_SLVERR && S_AXI_RDATA == 32'h0) else $error("bad read");
    a_unmapped_write: assert property (s_wr_take ##0 (S_AXI_AWADDR == 12'h118
        && !S_AXI_BVALID) |-> ##2 S_AXI_BVALID && S_AXI_BRESP == viq_pkg::RESP_SLVERR)
        else $error("unmapped write accepted");
    a_mask_quiet: assert property (dbg[1] && $past(dbg[1], 2) |->
        FAST_REQUEST_LINE_N && NORMAL_REQUEST_LINE_N) else $error("line active under mask");
    a_ack_release: assert property (s_rd_take ##0 (S_AXI_ARADDR ==
        viq_pkg::NORMAL_VECTOR_READ_OFS && !dbg[0] && !NORMAL_REQUEST_LINE_N)
        |=> NORMAL_REQUEST_LINE_N) else $error("normal line kept after acknowledge");
    a_fast_vector: assert property (s_rd_take ##0 (S_AXI_ARADDR ==
        viq_pkg::FAST_VECTOR_READ_OFS && !FAST_REQUEST_LINE_N) |=> S_AXI_RDATA == VECTOR_BASE)
        else $error("fast vector wrong");
endmodule // viq_regs_assertions

bind viq_regs viq_regs_assertions #(.VECTOR_BASE(VECTOR_BASE)) viq_regs_assertions_inst (
    .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .FAST_REQUEST_LINE_N(FAST_REQUEST_LINE_N),
    .NORMAL_REQUEST_LINE_N(NORMAL_REQUEST_LINE_N), .S_AXI_AWADDR(S_AXI_AWADDR),
    .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WDATA(S_AXI_WDATA),
    .S_AXI_WSTRB(S_AXI_WSTRB), .S_AXI_WVALID(S_AXI_WVALID), .S_AXI_WREADY(S_AXI_WREADY),
    .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
    .S_AXI_ARADDR(S_AXI_ARADDR), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
    .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RRESP(S_AXI_RRESP), .S_AXI_RVALID(S_AXI_RVALID));

// ===== sim/viq_source_model.sv
// peripheral source model: registered high level on the requested source bits for as long as fire is held
`timescale 1ns/1ps
module viq_source_model (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        fire,
    input  wire logic [31:0] fire_bits,
    output logic      [31:0] source_out
);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            source_out <= 32'h0;
        else
            source_out <= fire ? fire_bits : 32'h0;
    end
endmodule // viq_source_model

// ===== sim/viq_regs_test.sv
// self-checking bench for the vectored interrupt register block
`timescale 1ns/1ps
module viq_regs_test;
    localparam logic [11:0] PND = viq_pkg::PENDING_STATUS_OFS;
    localparam logic [11:0] MSK = viq_pkg::MASK_STATUS_OFS;
    localparam logic [11:0] LNS = viq_pkg::CORE_LINE_STATUS_OFS;
    localparam logic [11:0] ENA = viq_pkg::SOURCE_ENABLE_COMMAND_OFS;
    localparam logic [11:0] SETC = viq_pkg::PENDING_SET_COMMAND_OFS;
    localparam logic [11:0] CLR = viq_pkg::PENDING_CLEAR_COMMAND_OFS;
    localparam logic [11:0] EOS = viq_pkg::END_OF_SERVICE_COMMAND_OFS;
    localparam logic [11:0] SPV = viq_pkg::SPURIOUS_HANDLER_VECTOR_OFS;
    localparam logic [11:0] DBG = viq_pkg::DEBUG_CONTROL_OFS;
    localparam logic [11:0] VN = viq_pkg::NORMAL_VECTOR_READ_OFS;
    localparam logic [11:0] VF = viq_pkg::FAST_VECTOR_READ_OFS;
    localparam logic [31:0] VB = viq_pkg::VECTOR_BASE_DEFAULT;
    logic sys_clk = 1'b0, rst_n = 1'b0, fire = 1'b0;
    logic [31:0] fire_bits = 32'h0, src, wdata = 32'h0, rdata, d;
    logic [11:0] awaddr = 12'h0, araddr = 12'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, fast_n, normal_n;
    logic [1:0] bresp, rresp, r;
    int bad_count = 0, num_checks = 0, cycles = 0;
    always #5 sys_clk = ~sys_clk;
    viq_source_model viq_source_model_inst (.clk(sys_clk), .rst_n(rst_n), .fire(fire),
        .fire_bits(fire_bits), .source_out(src));
    viq_regs viq_regs_inst (.SYS_CLK(sys_clk), .RESET_N(rst_n), .SOURCE_IN(src),
        .FAST_REQUEST_LINE_N(fast_n), .NORMAL_REQUEST_LINE_N(normal_n),
        .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp);
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1'b1) begin
            @(posedge sys_clk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1'b1) begin
            @(posedge sys_clk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid) begin
                v = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask
    // every ordinary write must come back OKAY
    task automatic wc(input logic [11:0] a, input logic [31:0] v);
        wr(a, v, r);
        chk({30'h0, r}, 32'h0);
    endtask
    task automatic rc(input logic [11:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk(d, exp);
    endtask
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            end_sim();
        end
    end
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        chk({30'h0, normal_n, fast_n}, 32'h3);
        rc(PND, 32'h0);
        rc(MSK, 32'h0);
        rc(LNS, 32'h0);
        rc(SPV, 32'h0);
        rc(DBG, 32'h0);
        wc(ENA, 32'h6);
        wc(ENA, 32'h1);
        rc(MSK, 32'h7);
        wc(viq_pkg::SOURCE_DISABLE_COMMAND_OFS, 32'h2);
        rc(MSK, 32'h5);
        wc(SETC, 32'h10);
        rc(PND, 32'h10);
        rc(LNS, 32'h0);
        wc(ENA, 32'h10);
        rc(LNS, 32'h2);
        rc(VN, VB + 32'h10);
        rc(PND, 32'h0);
        wc(SETC, 32'h30);
        rc(LNS, 32'h0);
        rc(viq_pkg::CURRENT_ID_OFS, 32'h4);
        wc(EOS, 32'hdead_beef);
        rc(viq_pkg::CURRENT_ID_OFS, 32'h0);
        rc(LNS, 32'h2);
        wc(CLR, 32'h10);
        rc(PND, 32'h20);
        wc(SPV, 32'h0000_abc0);
        rc(VN, 32'h0000_abc0);
        rc(VF, 32'h0000_abc0);
        wc(SETC, 32'h1);
        rc(LNS, 32'h1);
        rc(VF, VB);
        wc(DBG, 32'h2);
        rc(LNS, 32'h0);
        rc(DBG, 32'h2);
        wc(DBG, 32'h0);
        rc(LNS, 32'h1);
        wc(CLR, 32'h1);
        wc(DBG, 32'h1);
        wc(SETC, 32'h10);
        rd(VN, d, r);
        chk(d, VB + 32'h10);
        rc(PND, 32'h30);
        wc(VN, 32'h0);
        rc(PND, 32'h20);
        wc(EOS, 32'h0);
        fire_bits <= 32'h8;
        fire <= 1'b1;
        @(posedge sys_clk);
        fire <= 1'b0;
        rc(PND, 32'h28);
        rd(12'h118, d, r);
        chk({30'h0, r}, {30'h0, viq_pkg::RESP_SLVERR});
        wr(12'h118, 32'h1, r);
        chk({30'h0, r}, {30'h0, viq_pkg::RESP_SLVERR});
        end_sim();
    end
endmodule // viq_regs_test
